// ===== logic/hsp_regs.svh
// Address, command, field and timing constants of the host serial port.
`ifndef HSP_REGS_SVH
`define HSP_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// Port addresses, as the 8-bit value of nibbles A3..A0 and B3..B0.
`define HSP_ADDR_WRITE       8'he8
`define HSP_ADDR_IRQ         8'hea
`define HSP_ADDR_RATE        8'heb
`define HSP_ADDR_CS          8'hec
`define HSP_ADDR_PC          8'hed

////////////////////////////////////////////////////////////////////////////
// Command addresses of the setting write address.
`define HSP_CMD_SYS1         4'h0
`define HSP_CMD_SRC_SWITCH   4'h5
`define HSP_CMD_IRQ_SELECT   4'h8
`define HSP_CMD_GP_OUT       4'ha
`define HSP_CMD_DATA_IO2     4'hd

////////////////////////////////////////////////////////////////////////////
// Field positions inside the 8-bit data byte (bit 0 is the first data bit).
`define HSP_BIT_OUT_DISABLE  1
`define HSP_BIT_LOCK_SRC     1
`define HSP_GP_OUT_LSB       4
`define HSP_BIT_FUNC_SEL     0
`define HSP_BIT_EXT_SEL      1
`define HSP_BIT_MCLK_INV     2
`define HSP_BIT_DATA_MUTE    3

////////////////////////////////////////////////////////////////////////////
// Interrupt source positions in the select byte and in the latch.
`define HSP_SRC_ERROR        0
`define HSP_SRC_NON_AUDIO    4
`define HSP_SRC_GPIO         6

////////////////////////////////////////////////////////////////////////////
// Reset values and frame lengths.
`define HSP_RST_IRQ_SELECT   8'h00
`define HSP_RST_GP_OUT       4'h0
`define HSP_ADDR_BITS        5'h08
`define HSP_FRAME_BITS       5'h10

////////////////////////////////////////////////////////////////////////////
// Timing: system clock rate and general-purpose input sample rate.
`define HSP_CLK_HZ           125000000
`define HSP_GP_SAMPLE_HZ     24000
`define HSP_GP_TICK_CYCLES   (`HSP_CLK_HZ / `HSP_GP_SAMPLE_HZ)

`endif

// ===== logic/hsp_pkg.sv
// Types shared by the host serial port modules.
package hsp_pkg;

  // Serial frame phases, one-hot.
  typedef enum logic [3:0]
  {
    st_addr  = 4'b0001,
    st_write = 4'b0010,
    st_read  = 4'b0100,
    st_skip  = 4'b1000
  } hsp_state_e;

  // Complete state of the control port.
  typedef struct packed
  {
    hsp_state_e  st;
    logic        sclk_prev;
    logic        ce_prev;
    logic [15:0] shift;
    logic [4:0]  bit_cnt;
    logic [15:0] rd_word;
    logic        do_drive;
    logic        do_bit;
    logic        do_oe_n;
    logic        out_disable;
    logic        lock_src;
    logic        func_sel;
    logic        ext_sel;
    logic        mclk_inv;
    logic        data_mute;
    logic [7:0]  irq_select;
    logic [3:0]  out_field;
    logic        irq_n;
    logic [7:0]  src_latch;
    logic        rx_error_pin_prev;
    logic        nonaudio_prev;
    logic [3:0]  gp_last;
    logic [3:0]  gp_hold;
    logic        gp_susp;
    logic [3:0]  gp_out;
    logic [3:0]  gp_oe_n;
    logic        mclk_o;
    logic        bclk_o;
    logic        lrck_o;
    logic        data_o;
  } hsp_main_s;

  // State of the sample rate divider.
  typedef struct packed
  {
    logic [15:0] cnt;
    logic        tick;
  } hsp_tick_s;

endpackage

// ===== logic/hsp_sample_tick.sv
// Divider that makes the general-purpose input sample strobe.
`include "hsp_regs.svh"

module hsp_sample_tick
#(
  parameter int unsigned CYCLES = `HSP_GP_TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // One-cycle strobe at the sample rate.
  output logic      tick
);
  import hsp_pkg::*;

  hsp_tick_s t_reg;
  hsp_tick_s t_next;

  // Count up one sample period; the strobe lasts one cycle.
  always_comb
  begin
    t_next = t_reg;
    t_next.tick = 1'b0;
    if (t_reg.cnt == 16'(CYCLES - 1))
    begin
      t_next.cnt = 16'h0000;
      t_next.tick = 1'b1; // [RL2]
    end
    else
    begin
      t_next.cnt = t_reg.cnt + 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  assign tick = t_reg.tick;

  // The strobe never stands two cycles, so one pin change is one sample.
  a_tick_single: assert property ( // [RL2]
    @(posedge clk) disable iff (rst) tick |=> !tick)
    else $error("sample strobe held for two cycles");

endmodule

// ===== logic/hsp_source_mux.sv
// Three-to-one selector: external audio pins, locked receiver signals, or crystal clocks with auxiliary data.
module hsp_source_mux
(
  // Selection controls.
  input  wire logic       ext_active,
  input  wire logic       inv_active,
  input  wire logic       mute_active,
  input  wire logic       pll_locked,
  input  wire logic       lock_src,
  // External audio on the general-purpose pins.
  input  wire logic [3:0] gp_pin_in,
  // Receiver clocks and data.
  input  wire logic       pll_mclk,
  input  wire logic       pll_bclk,
  input  wire logic       pll_lrck,
  input  wire logic       pll_data,
  input  wire logic       xtal_mclk,
  input  wire logic       xtal_bclk,
  input  wire logic       xtal_lrck,
  input  wire logic       aux_serial_data_in,
  // Selected signals.
  output logic            mclk,
  output logic            bclk,
  output logic            lrck,
  output logic            data
);

  logic use_pll_clk;

  // The crystal clocks may replace the locked clocks on request.
  assign use_pll_clk = pll_locked & ~lock_src;

  // External pins win; otherwise lock state picks the receiver source.
  always_comb
  begin
    if (ext_active)
    begin
      mclk = gp_pin_in[0] ^ inv_active; // [RL8] [RL10]
      bclk = gp_pin_in[1];
      lrck = gp_pin_in[2];
      data = gp_pin_in[3] & ~mute_active; // [RL10]
    end
    else
    begin
      mclk = use_pll_clk ? pll_mclk : xtal_mclk; // [RL8]
      bclk = use_pll_clk ? pll_bclk : xtal_bclk;
      lrck = use_pll_clk ? pll_lrck : xtal_lrck;
      data = pll_locked ? pll_data : aux_serial_data_in;
    end
  end

endmodule

// ===== logic/hsp_ctrl_port.sv
// Serial control port, interrupt request, GP input and audio selector.
//
// Summary of operation
// [RL1] Parallel input pins read at address EB.
// [RL2] Interrupt mode samples pins at 24 kHz.
// [RL3] Pin change pulls request low, suspends sampling.
// [RL4] Reading EA releases request, freezes holding value.
// [RL5] Reading parallel field clears the holding value.
// [RL6] New change before read refreshes holding value.
// [RL7] Polled mode captures pins at address EB.
// [RL8] Selector routes pins or receiver clocks out.
// [RL9] External select acts only in selector mode.
// [RL10] Selector mode may invert clock, mute data.
// [RL11] Host sets selector only in master mode.
// [RL12] Request idles high, only EA read releases.
// [RL13] Request is OR of selected sources.
// [RL14] Eight interrupt sources exist.
// [RL15] Sources latched, error and non-audio live.
// [RL16] Host keeps crystal running for rate sources.
// [RL17] Fields travel LSB first; output three-state.
// [RL18] Each address is read-only or write-only.
// [RL19] Write frame: address, chip, zeros, command, data.
// [RL20] Output floats with enable low, drives after.
// [RL21] Output disable keeps serial output floating.
// [RL22] Idle-high clock lowered before read enable.
// [RL23] Host never writes test commands 11, 15.
// [RL24] Output mode drives written bits on pins.
// [RL25] Bits taken on rising clock; apply at end.
`include "hsp_regs.svh"

module hsp_ctrl_port
#(
  parameter int unsigned GP_TICK_CYCLES = `HSP_GP_TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial control port.
  input  wire logic        ctrl_chip_enable,
  input  wire logic        ctrl_serial_clock,
  input  wire logic        ctrl_serial_in,
  output logic             ctrl_serial_out,
  output logic             ctrl_serial_out_oe_n,
  input  wire logic        chip_addr_high,
  input  wire logic        chip_addr_low,
  // Interrupt request.
  output logic             irq_request_n,
  // Interrupt sources.
  input  wire logic        rx_error_pin,
  input  wire logic        non_audio_pin,
  input  wire logic        input_presence_change_irq,
  input  wire logic        rate_change_irq,
  input  wire logic        chan_status_update_irq,
  input  wire logic        burst_preamble_update_irq,
  input  wire logic        emphasis_change_irq,
  // Read data from the receiver.
  input  wire logic [7:0]  detect_status,
  input  wire logic [11:0] rate_status,
  input  wire logic [15:0] chan_status_word,
  input  wire logic [15:0] burst_preamble_word,
  // General-purpose pins.
  input  wire logic        gp_output_mode,
  input  wire logic [3:0]  gp_pin_in,
  output logic [3:0]       gp_pin_out,
  output logic [3:0]       gp_pin_oe_n,
  // Receiver clock and data sources.
  input  wire logic        pll_locked,
  input  wire logic        pll_mclk,
  input  wire logic        pll_bclk,
  input  wire logic        pll_lrck,
  input  wire logic        pll_data,
  input  wire logic        xtal_mclk,
  input  wire logic        xtal_bclk,
  input  wire logic        xtal_lrck,
  input  wire logic        aux_serial_data_in,
  // Selector outputs.
  output logic             rx_master_clock_out,
  output logic             rx_bit_clock_out,
  output logic             rx_word_clock_out,
  output logic             rx_data_out
);
  import hsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations.

  hsp_main_s   state_reg;
  hsp_main_s   state_next;
  logic        sclk_rise;
  logic        ce_rise;
  logic        ce_fall;
  logic [7:0]  port_addr;
  logic        addr_ok;
  logic        read_addr;
  logic        ea_access;
  logic        eb_access;
  logic        gp_tick;
  logic        gp_parallel;
  logic        gp_int_mode;
  logic        gp_poll_mode;
  logic        gp_change;
  logic [7:0]  src_event;
  logic [7:0]  src_view;
  logic        irq_hit;
  logic [15:0] snapshot;
  logic        chip_match;
  logic        ext_active;
  logic        mux_mclk;
  logic        mux_bclk;
  logic        mux_lrck;
  logic        mux_data;

  // Bits arrive A0..A3 then B0..B3, so the nibbles come in swapped.
  function automatic logic [7:0] wire_addr(input logic [7:0] raw);
    wire_addr = {raw[3:0], raw[7:4]}; // [RL17] [RL18]
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Edge detection and address decode.

  // Pins are synchronous, so one stored copy is enough to find edges.
  assign sclk_rise = ctrl_serial_clock & ~state_reg.sclk_prev; // [RL25]
  assign ce_rise   = ctrl_chip_enable & ~state_reg.ce_prev;
  assign ce_fall   = ~ctrl_chip_enable & state_reg.ce_prev;
  assign port_addr = wire_addr(state_reg.shift[15:8]);
  assign addr_ok   = (state_reg.bit_cnt >= `HSP_ADDR_BITS);
  assign read_addr = (port_addr == `HSP_ADDR_IRQ) ||
                     (port_addr == `HSP_ADDR_RATE) ||
                     (port_addr == `HSP_ADDR_CS) ||
                     (port_addr == `HSP_ADDR_PC); // [RL18]
  assign ea_access = state_reg.st[0] & ce_rise & addr_ok &
                     (port_addr == `HSP_ADDR_IRQ);
  assign eb_access = state_reg.st[0] & ce_rise & addr_ok &
                     (port_addr == `HSP_ADDR_RATE);
  assign chip_match = (state_reg.shift[0] == chip_addr_low) &&
                      (state_reg.shift[1] == chip_addr_high);

  ////////////////////////////////////////////////////////////////////////
  // Interrupt sources and general-purpose input modes.

  assign gp_parallel  = ~gp_output_mode & ~state_reg.func_sel;
  assign gp_int_mode  = gp_parallel & state_reg.irq_select[`HSP_SRC_GPIO];
  assign gp_poll_mode = gp_parallel & ~gp_int_mode;
  assign gp_change    = gp_tick & gp_int_mode &
                        (gp_pin_in != state_reg.gp_last); // [RL3]

  // Pin level changes are found here; other sources arrive as pulses.
  assign src_event = {emphasis_change_irq,
                      gp_change,
                      burst_preamble_update_irq,
                      non_audio_pin ^ state_reg.nonaudio_prev,
                      chan_status_update_irq,
                      rate_change_irq,
                      input_presence_change_irq,
                      rx_error_pin ^ state_reg.rx_error_pin_prev}; // [RL14]
  assign irq_hit = |(src_event & state_reg.irq_select); // [RL13]

  // Error and non-audio report the pin level at read time.
  always_comb
  begin
    src_view = state_reg.src_latch; // [RL15]
    src_view[`HSP_SRC_ERROR] = rx_error_pin;
    src_view[`HSP_SRC_NON_AUDIO] = non_audio_pin;
  end

  // Word handed to the shifter when a read frame opens.
  always_comb
  begin
    case (port_addr)
      `HSP_ADDR_IRQ:  snapshot = {src_view, detect_status};
      `HSP_ADDR_RATE: snapshot = {rate_status, gp_poll_mode ? gp_pin_in
                                  : state_reg.gp_hold}; // [RL1] [RL7]
      `HSP_ADDR_CS:   snapshot = chan_status_word;
      `HSP_ADDR_PC:   snapshot = burst_preamble_word;
      default:        snapshot = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Selector.

  assign ext_active = ~gp_output_mode & state_reg.func_sel &
                      state_reg.ext_sel; // [RL9]

  hsp_source_mux u_mux
  (
    .ext_active         (ext_active),
    .inv_active         (state_reg.func_sel & state_reg.mclk_inv),
    .mute_active        (state_reg.func_sel & state_reg.data_mute),
    .pll_locked         (pll_locked),
    .lock_src           (state_reg.lock_src),
    .gp_pin_in          (gp_pin_in),
    .pll_mclk           (pll_mclk),
    .pll_bclk           (pll_bclk),
    .pll_lrck           (pll_lrck),
    .pll_data           (pll_data),
    .xtal_mclk          (xtal_mclk),
    .xtal_bclk          (xtal_bclk),
    .xtal_lrck          (xtal_lrck),
    .aux_serial_data_in (aux_serial_data_in),
    .mclk               (mux_mclk),
    .bclk               (mux_bclk),
    .lrck               (mux_lrck),
    .data               (mux_data)
  );

  hsp_sample_tick #(.CYCLES(GP_TICK_CYCLES)) u_tick
  (
    .clk  (clk),
    .rst  (rst),
    .tick (gp_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  // A clock edge that meets the enable falling edge is dropped on purpose.
  always_comb
  begin
    state_next = state_reg;
    state_next.sclk_prev = ctrl_serial_clock;
    state_next.ce_prev = ctrl_chip_enable;
    state_next.rx_error_pin_prev = rx_error_pin;
    state_next.nonaudio_prev = non_audio_pin;
    case (state_reg.st)
      st_addr:
      begin
        if (ce_rise)
        begin
          state_next.shift = 16'h0000;
          state_next.bit_cnt = 5'h00;
          if (addr_ok && port_addr == `HSP_ADDR_WRITE)
            state_next.st = st_write;
          else if (addr_ok && read_addr)
          begin
            state_next.st = st_read;
            state_next.rd_word = snapshot;
            state_next.do_bit = snapshot[0];
            state_next.do_drive = 1'b1; // [RL20]
          end
          else
            state_next.st = st_skip;
        end
        else if (sclk_rise)
        begin
          state_next.shift = {ctrl_serial_in, state_reg.shift[15:1]};
          if (state_reg.bit_cnt != `HSP_FRAME_BITS)
            state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
        end
      end
      st_write:
      begin
        if (ce_fall)
        begin
          state_next.st = st_addr;
          state_next.bit_cnt = 5'h00;
          if (state_reg.bit_cnt == `HSP_FRAME_BITS && chip_match &&
              state_reg.shift[3:2] == 2'b00) // [RL19] [RL25]
          begin
            case (state_reg.shift[7:4])
              `HSP_CMD_SYS1:
                state_next.out_disable =
                  state_reg.shift[8 + `HSP_BIT_OUT_DISABLE];
              `HSP_CMD_SRC_SWITCH:
                state_next.lock_src = state_reg.shift[8 + `HSP_BIT_LOCK_SRC];
              `HSP_CMD_IRQ_SELECT:
                state_next.irq_select = state_reg.shift[15:8];
              `HSP_CMD_GP_OUT:
                state_next.out_field =
                  state_reg.shift[8 + `HSP_GP_OUT_LSB +: 4];
              `HSP_CMD_DATA_IO2:
              begin
                state_next.func_sel  = state_reg.shift[8 + `HSP_BIT_FUNC_SEL];
                state_next.ext_sel   = state_reg.shift[8 + `HSP_BIT_EXT_SEL];
                state_next.mclk_inv  = state_reg.shift[8 + `HSP_BIT_MCLK_INV];
                state_next.data_mute = state_reg.shift[8 + `HSP_BIT_DATA_MUTE];
              end
              default:
                state_next.st = st_addr;
            endcase
          end
        end
        else if (sclk_rise)
        begin
          state_next.shift = {ctrl_serial_in, state_reg.shift[15:1]};
          if (state_reg.bit_cnt != `HSP_FRAME_BITS)
            state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
        end
      end
      st_read:
      begin
        if (ce_fall)
        begin
          state_next.st = st_addr;
          state_next.do_drive = 1'b0; // [RL20]
        end
        else if (sclk_rise)
        begin
          state_next.rd_word = {1'b0, state_reg.rd_word[15:1]}; // [RL17]
          state_next.do_bit = state_reg.rd_word[1];
        end
      end
      st_skip:
      begin
        if (ce_fall)
          state_next.st = st_addr;
      end
      default:
        state_next.st = st_addr;
    endcase

    // A new source in the clearing cycle keeps the request low.
    if (irq_hit)
      state_next.irq_n = 1'b0; // [RL12] [RL13]
    else if (ea_access)
      state_next.irq_n = 1'b1; // [RL4] [RL12]
    state_next.src_latch = (ea_access ? 8'h00 : state_reg.src_latch) |
                           (src_event & state_reg.irq_select); // [RL15]

    // Holding register: read clears first, so a same-cycle change wins.
    if (eb_access)
    begin
      state_next.gp_hold = 4'h0; // [RL5]
      state_next.gp_susp = 1'b0;
    end
    if (ea_access && gp_int_mode)
      state_next.gp_susp = 1'b1; // [RL4]
    if (gp_tick && gp_int_mode)
    begin
      state_next.gp_last = gp_pin_in;
      if (gp_change)
      begin
        state_next.gp_hold = gp_pin_in; // [RL3] [RL6]
        state_next.gp_susp = 1'b1;
      end
      else if (!state_next.gp_susp)
        state_next.gp_hold = gp_pin_in; // [RL2]
    end

    // Pin and selector outputs, registered.
    state_next.gp_out = state_reg.out_field; // [RL24]
    state_next.gp_oe_n = gp_output_mode ? 4'h0 : 4'hf;
    state_next.mclk_o = mux_mclk;
    state_next.bclk_o = mux_bclk;
    state_next.lrck_o = mux_lrck;
    state_next.data_o = mux_data;
    state_next.do_oe_n = ~(state_next.do_drive &
                           ~state_next.out_disable); // [RL21]
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.st <= st_addr;
      state_reg.irq_n <= 1'b1;
      state_reg.do_oe_n <= 1'b1;
      state_reg.gp_oe_n <= 4'hf;
      state_reg.irq_select <= `HSP_RST_IRQ_SELECT;
      state_reg.out_field <= `HSP_RST_GP_OUT;
    end
    else
      state_reg <= state_next;
  end

  assign ctrl_serial_out      = state_reg.do_bit;
  assign ctrl_serial_out_oe_n = state_reg.do_oe_n;
  assign irq_request_n        = state_reg.irq_n;
  assign gp_pin_out           = state_reg.gp_out;
  assign gp_pin_oe_n          = state_reg.gp_oe_n;
  assign rx_master_clock_out  = state_reg.mclk_o;
  assign rx_bit_clock_out     = state_reg.bclk_o;
  assign rx_word_clock_out    = state_reg.lrck_o;
  assign rx_data_out          = state_reg.data_o;

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_read_open;
    state_reg.st[0] && ce_rise && addr_ok && read_addr;
  endsequence

  a_irq_on_source: assert property ( // [RL13]
    irq_hit |=> !irq_request_n)
    else $error("selected source did not pull the request low");
  a_irq_release: assert property ( // [RL12]
    $rose(irq_request_n) |-> $past(ea_access))
    else $error("request released without an EA read");
  a_ea_clears_irq: assert property ( // [RL4]
    ea_access && !irq_hit |=> irq_request_n)
    else $error("EA read did not release the request");
  a_po_read_clears: assert property ( // [RL5]
    eb_access && !gp_tick |=> state_reg.gp_hold == 4'h0)
    else $error("parallel field not cleared after read");
  a_poll_capture: assert property ( // [RL7]
    eb_access && gp_poll_mode |=> state_reg.rd_word[3:0] == $past(gp_pin_in))
    else $error("polled read did not capture pin levels");
  a_gp_suspend: assert property ( // [RL3]
    state_reg.gp_susp && !eb_access && !gp_change |=> $stable(state_reg.gp_hold))
    else $error("holding value moved while suspended");
  a_do_float: assert property ( // [RL20]
    !ctrl_chip_enable |=> ctrl_serial_out_oe_n)
    else $error("serial output driven with enable low");
  a_do_drive: assert property ( // [RL20]
    s_read_open ##1 !state_reg.out_disable |-> !ctrl_serial_out_oe_n)
    else $error("serial output not driven after read address");
  a_do_disabled: assert property ( // [RL21]
    state_reg.out_disable |-> ctrl_serial_out_oe_n)
    else $error("serial output driven while disabled");
  a_mux_ext: assert property ( // [RL8]
    ext_active |=> rx_bit_clock_out == $past(gp_pin_in[1]))
    else $error("external bit clock not routed");
  a_mux_plain: assert property ( // [RL9]
    !state_reg.func_sel && pll_locked |=>
    rx_data_out == $past(pll_data))
    else $error("receiver data not routed outside selector mode");
  a_gp_outputs: assert property ( // [RL24]
    gp_output_mode |=> gp_pin_oe_n == 4'h0 &&
    gp_pin_out == $past(state_reg.out_field))
    else $error("output field not driven on pins");

endmodule

// ===== tb/hsp_host_model.sv
// Host microcontroller model that drives the serial control port.
module hsp_host_model
(
  // Clock.
  input  wire logic clk,
  // Serial port pins.
  output logic      ce,
  output logic      sck,
  output logic      sdi,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // Idle low clock and enable from time zero.
  initial
  begin
    ce = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end

  // Every level stands two clocks, so the device sees each edge.
  task automatic step();
    repeat (2) @(negedge clk);
  endtask

  // One bit and one full clock pulse.
  task automatic put(input logic b);
    sdi = b;
    sck = 1'b1;
    step();
    sck = 1'b0;
    step();
  endtask

  // Address nibbles, high one first, each low bit first, then enable up.
  task automatic open(input logic [7:0] a);
    @(negedge clk);
    ce = 1'b0;
    for (int i = 0; i < 8; i++)
      put(a[(i + 4) % 8]);
    sdi = ~sdi; // A released line must not keep its old level.
    ce = 1'b1;
    step();
  endtask

  // Write frame with chip address zero and two zero bits.
  task automatic write(input logic [3:0] cmd, input logic [7:0] d);
    logic [15:0] w;
    w = {d, cmd, 4'h0};
    open(8'he8);
    for (int i = 0; i < 16; i++)
      put(w[i]);
    ce = 1'b0;
    sdi = ~sdi;
    step();
  endtask

  // Read frame; the clock idles low so no lowering is needed first.
  task automatic read(input logic [7:0] a, output logic [15:0] q);
    open(a);
    for (int i = 0; i < 16; i++)
    begin
      q[i] = dout;
      put(1'b0);
    end
    ce = 1'b0;
    step();
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the host serial port.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [15:0] e;} hsp_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        z = 1'b0;
  logic        ce, sck, sdi, dout, doe_n, irq_n, drove;
  logic        lk = 1'b1;
  logic        gpo = 1'b0;
  logic [3:0]  gpv;
  logic [3:0]  gpe;
  logic [3:0]  gp = 4'h0;
  logic [3:0]  pl = 4'ha;
  logic [3:0]  rx;
  logic [15:0] q;
  logic [7:0]  ds = 8'h5a;
  logic [11:0] rs = 12'h123;
  logic [15:0] cs = 16'h1234;
  logic [15:0] bp = 16'ha5c3;
  int          num_errors = 0;
  int          tests_run = 0;
  hsp_row_s    rows [2] = '{'{8'hec, 16'h1234}, '{8'hed, 16'ha5c3}};

  ////////////////////////////////////////////////////////////////////////
  // Clock, partner and device; a short sample period keeps the run brief.
  always #4 clk = ~clk; // Runs free, like a crystal kept going.
  always @(posedge clk) drove <= drove | ~doe_n;
  // A released output shows the host the inverse of its last bit.
  hsp_host_model host (.clk, .ce, .sck, .sdi, .dout(doe_n ? ~dout : dout));
  hsp_ctrl_port #(.GP_TICK_CYCLES(8)) i_hsp_ctrl_port
  (
    .clk, .rst, .ctrl_chip_enable(ce), .ctrl_serial_clock(sck),
    .ctrl_serial_in(sdi), .ctrl_serial_out(dout), .ctrl_serial_out_oe_n(doe_n),
    .chip_addr_high(z), .chip_addr_low(z), .irq_request_n(irq_n),
    .rx_error_pin(z), .non_audio_pin(z), .input_presence_change_irq(z),
    .rate_change_irq(z), .chan_status_update_irq(z),
    .burst_preamble_update_irq(z), .emphasis_change_irq(z),
    .detect_status(ds), .rate_status(rs), .chan_status_word(cs),
    .burst_preamble_word(bp), .gp_output_mode(gpo), .gp_pin_in(gp),
    .gp_pin_out(gpv), .gp_pin_oe_n(gpe), .pll_locked(lk), .pll_mclk(pl[0]),
    .pll_bclk(pl[1]), .pll_lrck(pl[2]), .pll_data(pl[3]), .xtal_mclk(z),
    .xtal_bclk(z), .xtal_lrck(z), .aux_serial_data_in(z),
    .rx_master_clock_out(rx[0]), .rx_bit_clock_out(rx[1]),
    .rx_word_clock_out(rx[2]), .rx_data_out(rx[3])
  );

  // Counts and reports a mismatch.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bounded wait for the request level; a hang ends the run as a failure.
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_n !== lvl && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 200)
    begin
      num_errors++;
      test_done();
    end
  endtask

  // Writes a setting as for a master-mode device, then lets outputs settle.
  task automatic sel(input logic [3:0] c, input logic [7:0] d);
    host.write(c, d);
    repeat (4) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    drove = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(16'(irq_n), 16'h1);
    check(16'(doe_n), 16'h1);
    host.write(4'h8, 8'h40);
    repeat (20) @(negedge clk);
    gp = 4'h9;
    wait_irq(1'b0);
    foreach (rows[i])
    begin
      host.read(rows[i].a, q);
      check(q, rows[i].e);
    end
    check(16'(irq_n), 16'h0);
    host.read(8'hea, q);
    check(q, 16'h405a);
    check(16'(irq_n), 16'h1);
    host.read(8'heb, q);
    check(q, 16'h1239);
    sel(4'h8, 8'h00);
    gp = 4'h6;
    host.read(8'heb, q);
    check(q, 16'h1236);
    sel(4'hd, 8'h03);
    check(16'(rx), 16'h6);
    sel(4'hd, 8'h0f);
    check(16'(rx), 16'h7);
    sel(4'hd, 8'h0e);
    check(16'(rx), 16'ha);
    lk = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(rx), 16'h0);
    gpo = 1'b1;
    sel(4'ha, 8'h50);
    check(16'({gpe, gpv}), 16'h0005);
    sel(4'h0, 8'h02);
    drove = 1'b0;
    host.read(8'hec, q);
    check(16'(drove), 16'h0);
    test_done();
  end
endmodule
